// File: logic/smbus_ext_pkg.sv
// Contract
// - Alert works only in interrupt mode with active-low polarity.
// - Start plus address 00011001; an alerting slave acknowledges it.
// - Then the device sends address 1001 and the select pin levels.
// - Eighth bit is one for an upper-limit trip, zero for a lower one.
// - Losing arbitration means no acknowledge and the alert stays asserted.
// - The winner releases its alert after sending its address byte.
// - SCL low past the stuck limit resets the interface and releases SDA.
// - After a timeout reset a new Start is taken before the maximum limit.
// - General call acknowledged only with write bit; then a command.
// - Command 04h re-samples the address pins.
// - Command 06h re-latches pins and resets registers within reset time.
// - Mode select zero (reset default) is comparator; one is interrupt.
package smbus_ext_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam logic [7:0] ALERT_RESP_ADDR = 8'h19;
    localparam logic [3:0] DEV_ADDR_HI = 4'h9;
    localparam logic [7:0] GEN_CALL_WRITE = 8'h00;
    localparam logic [7:0] CMD_RELATCH = 8'h04;
    localparam logic [7:0] CMD_RESET = 8'h06;
    localparam int unsigned STUCK_MS = 25;
    localparam int unsigned STUCK_CYCLES = STUCK_MS * (CLK_HZ / 1000);
    localparam int unsigned RESET_BUSY_US = 500;
    localparam int unsigned RESET_BUSY_CYCLES =
        RESET_BUSY_US * (CLK_HZ / 1_000_000);
    localparam logic [2:0] ADDR_PINS_RESET = 3'h0;
    localparam logic [1:0] PIN_SETTLE_CYCLES = 2'h3;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_SEND = 4'h3,
        ST_SEND_ACK = 4'h4,
        ST_CMD = 4'h5,
        ST_CMD_ACK = 4'h6,
        ST_IGNORE = 4'h7
    } link_state_t;
endpackage

// File: logic/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            stage1 <= '1;
            sync_o <= '1;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule
`default_nettype wire

// File: logic/smbus_alert_timeout_gencall.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_alert_timeout_gencall #(
    parameter int unsigned STUCK_CYCLES = smbus_ext_pkg::STUCK_CYCLES,
    parameter int unsigned BUSY_CYCLES = smbus_ext_pkg::RESET_BUSY_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [2:0] address_select_pins_i,
    input wire logic alarm_mode_select_i,
    input wire logic alarm_polarity_i,
    input wire logic alarm_event_i,
    input wire logic alarm_upper_i,
    output logic alert_o,
    output logic alert_oe_n_o,
    output logic regs_reset_o,
    output logic busy_o,
    output logic [2:0] dev_addr_low_o
);
    logic [4:0] pins_s;
    logic scl, sda, scl_d, sda_d;
    pin_sync #(.WIDTH(5)) u_sync (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .async_i({address_select_pins_i, scl_i, sda_i}),
        .sync_o(pins_s)
    );
    assign scl = pins_s[1];
    assign sda = pins_s[0];

    smbus_ext_pkg::link_state_t state;
    logic [7:0] shreg;
    logic [3:0] bitcnt;
    logic alert_pend, alert_lim, is_gc, won, drive_low;
    logic [31:0] stuck_cnt, busy_cnt;
    logic [2:0] addr_lat;
    logic relatch_pend;
    logic [1:0] settle_cnt;

    wire start_c = scl && scl_d && sda_d && !sda;
    wire stop_c = scl && scl_d && !sda_d && sda;
    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    wire stuck = (stuck_cnt >= STUCK_CYCLES - 1);
    wire alert_en = alarm_mode_select_i && !alarm_polarity_i;
    wire [7:0] next_shreg = {shreg[6:0], sda};
    wire [7:0] resp_byte = {smbus_ext_pkg::DEV_ADDR_HI, addr_lat, alert_lim};
    wire is_ara = shreg == smbus_ext_pkg::ALERT_RESP_ADDR;
    wire is_gcw = shreg == smbus_ext_pkg::GEN_CALL_WRITE;
    wire is_cmd_relatch = next_shreg == smbus_ext_pkg::CMD_RELATCH;
    wire is_cmd_reset = next_shreg == smbus_ext_pkg::CMD_RESET;
    wire cmd_done = state == smbus_ext_pkg::ST_CMD && scl_rise
                    && bitcnt == 4'h7;
    wire pins_settled = settle_cnt == smbus_ext_pkg::PIN_SETTLE_CYCLES;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
        end
    end

    // Bus stuck counter
    always_ff @(posedge core_clk_i) begin
        if (rst_i || scl) begin
            stuck_cnt <= 32'h0;
        end else if (!stuck) begin
            stuck_cnt <= stuck_cnt + 32'h1;
        end
    end

    // Alert latch: a new event wins over the response clear but not over a register reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i || regs_reset_o) begin
            alert_pend <= 1'b0;
            alert_lim <= 1'b0;
        end else if (alarm_event_i && alert_en) begin
            alert_pend <= 1'b1;
            alert_lim <= alarm_upper_i;
        end else if (!alert_en) begin
            alert_pend <= 1'b0;
        end else if (state == smbus_ext_pkg::ST_SEND_ACK && won
                     && scl_fall && !is_gc) begin
            alert_pend <= 1'b0;
        end
    end

    // Pin settle counter: synchroniser still shows its reset level
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            settle_cnt <= 2'h0;
        end else if (!pins_settled) begin
            settle_cnt <= settle_cnt + 2'h1;
        end
    end

    // Address latch and general call reset pulse
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            relatch_pend <= 1'b1;
            addr_lat <= smbus_ext_pkg::ADDR_PINS_RESET;
            busy_cnt <= 32'h0;
        end else begin
            if (relatch_pend && pins_settled) begin
                addr_lat <= pins_s[4:2];
                relatch_pend <= 1'b0;
            end
            if (cmd_done) begin
                if (is_cmd_relatch || is_cmd_reset) begin
                    relatch_pend <= 1'b1;
                end
                if (is_cmd_reset) begin
                    busy_cnt <= BUSY_CYCLES;
                end
            end else if (busy_cnt != 32'h0) begin
                busy_cnt <= busy_cnt - 32'h1;
            end
        end
    end
    assign busy_o = busy_cnt != 32'h0;
    assign regs_reset_o = busy_cnt == BUSY_CYCLES;
    assign dev_addr_low_o = addr_lat;

    // Serial state machine
    always_ff @(posedge core_clk_i) begin
        if (rst_i || stuck) begin
            state <= smbus_ext_pkg::ST_IDLE;
            drive_low <= 1'b0;
            bitcnt <= 4'h0;
            shreg <= 8'h00;
            is_gc <= 1'b0;
            won <= 1'b0;
        end else if (start_c) begin
            state <= smbus_ext_pkg::ST_ADDR;
            drive_low <= 1'b0;
            bitcnt <= 4'h0;
        end else if (stop_c) begin
            state <= smbus_ext_pkg::ST_IDLE;
            drive_low <= 1'b0;
        end else begin
            unique case (state)
                smbus_ext_pkg::ST_IDLE, smbus_ext_pkg::ST_IGNORE: begin
                    drive_low <= 1'b0;
                end
                smbus_ext_pkg::ST_ADDR, smbus_ext_pkg::ST_CMD: begin
                    if (scl_rise) begin
                        shreg <= next_shreg;
                        bitcnt <= bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == 4'h8) begin
                        bitcnt <= 4'h0;
                        if (state == smbus_ext_pkg::ST_CMD) begin
                            state <= smbus_ext_pkg::ST_CMD_ACK;
                            drive_low <= 1'b1;
                        end else if (is_ara && alert_pend && alert_en) begin
                            state <= smbus_ext_pkg::ST_ADDR_ACK;
                            drive_low <= 1'b1;
                            is_gc <= 1'b0;
                        end else if (is_gcw && !busy_o) begin
                            state <= smbus_ext_pkg::ST_ADDR_ACK;
                            drive_low <= 1'b1;
                            is_gc <= 1'b1;
                        end else begin
                            state <= smbus_ext_pkg::ST_IGNORE;
                        end
                    end
                end
                smbus_ext_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (is_gc) begin
                            state <= smbus_ext_pkg::ST_CMD;
                            drive_low <= 1'b0;
                        end else begin
                            state <= smbus_ext_pkg::ST_SEND;
                            shreg <= resp_byte;
                            drive_low <= !resp_byte[7];
                            won <= 1'b1;
                        end
                    end
                end
                smbus_ext_pkg::ST_SEND: begin
                    if (scl_rise && drive_low == 1'b0 && !sda) begin
                        won <= 1'b0;
                        state <= smbus_ext_pkg::ST_IGNORE;
                    end else if (scl_fall) begin
                        shreg <= {shreg[6:0], 1'b1};
                        bitcnt <= bitcnt + 4'h1;
                        drive_low <= !shreg[6] && bitcnt != 4'h7;
                        if (bitcnt == 4'h7) begin
                            state <= smbus_ext_pkg::ST_SEND_ACK;
                        end
                    end
                end
                smbus_ext_pkg::ST_SEND_ACK: begin
                    if (scl_fall) begin
                        state <= smbus_ext_pkg::ST_IGNORE;
                    end
                end
                smbus_ext_pkg::ST_CMD_ACK: begin
                    if (scl_fall) begin
                        state <= smbus_ext_pkg::ST_IGNORE;
                        drive_low <= 1'b0;
                    end
                end
                default: begin
                    state <= smbus_ext_pkg::ST_IDLE;
                end
            endcase
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = !drive_low;
    assign alert_o = 1'b0;
    assign alert_oe_n_o = !alert_pend;
endmodule
`default_nettype wire

// File: sim/smbus_alert_timeout_gencall_checker.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_alert_timeout_gencall_checker #(
    parameter int unsigned STUCK_CYCLES = 200,
    parameter int unsigned BUSY_CYCLES = 20
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic alarm_mode_select_i,
    input wire logic alarm_polarity_i,
    input wire logic alert_o,
    input wire logic alert_oe_n_o,
    input wire logic regs_reset_o,
    input wire logic busy_o
);
    int unsigned low_cnt;
    int unsigned busy_cnt;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    always_ff @(posedge core_clk_i) begin
        low_cnt <= (rst_i || scl_i) ? 0 : low_cnt + 1;
        busy_cnt <= (rst_i || !busy_o) ? 0 : busy_cnt + 1;
    end
    sequence s_cmp_mode;
        !alarm_mode_select_i [*4];
    endsequence
    sequence s_pol_high;
        alarm_polarity_i [*4];
    endsequence
    AST_OD_DATA: assert property (!sda_oe_n_o |-> !sda_o)
        else $error("data pin driven high");
    AST_OD_ALERT: assert property (!alert_oe_n_o |-> !alert_o)
        else $error("alert pin driven high");
    AST_CMP_QUIET: assert property (s_cmp_mode |-> alert_oe_n_o)
        else $error("alert in comparator mode");
    AST_POL_QUIET: assert property (s_pol_high |-> alert_oe_n_o)
        else $error("alert with active-high polarity");
    AST_SDA_EDGE: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data changed while clock high");
    AST_ALERT_CLEAR: assert property ($rose(alert_oe_n_o)
        && alarm_mode_select_i && !alarm_polarity_i
        && !$past(regs_reset_o) |-> !scl_i)
        else $error("alert released while clock high");
    AST_STUCK_FREE: assert property (
        low_cnt > STUCK_CYCLES + 8 |-> sda_oe_n_o)
        else $error("data held past stuck limit");
    AST_BUSY_MAX: assert property (busy_cnt < BUSY_CYCLES + 2)
        else $error("busy too long");
    AST_RST_PULSE: assert property (regs_reset_o |=> !regs_reset_o)
        else $error("register reset not a pulse");
endmodule
bind smbus_alert_timeout_gencall smbus_alert_timeout_gencall_checker #(
    .STUCK_CYCLES(STUCK_CYCLES), .BUSY_CYCLES(BUSY_CYCLES)) u_chk (.*);
`default_nettype wire

// File: sim/smbus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_master_model (
    input wire logic core_clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o
);
    int half = 10;
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick();
        repeat (half) @(posedge core_clk_i);
    endtask
    task automatic start();
        sda_o <= 1'b1;
        tick();
        scl_o <= 1'b1;
        tick();
        sda_o <= 1'b0;
        tick();
        scl_o <= 1'b0;
    endtask
    task automatic bits(input logic [8:0] tx, input int n,
        output logic [8:0] rx);
        rx = 9'h1ff;
        for (int i = 8; i > 8 - n; i--) begin
            repeat (2) @(posedge core_clk_i);
            sda_o <= tx[i];
            tick();
            scl_o <= 1'b1;
            tick();
            rx[i] = sda_line_i;
            scl_o <= 1'b0;
        end
    endtask
    task automatic stop();
        tick();
        sda_o <= 1'b0;
        tick();
        scl_o <= 1'b1;
        tick();
        sda_o <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: sim/smbus_alert_timeout_gencall_bench.sv
`timescale 1ns/10ps
`default_nettype none
module smbus_alert_timeout_gencall_bench;
    logic core_clk_i = 1'b0, rst_i = 1'b1, mode = 1'b1, alarm_polarity = 1'b0;
    logic ev = 1'b0, up = 1'b0, peer = 1'b1, sda_o, sda_oe_n_o, alert_o;
    logic alert_oe_n_o, regs_reset_o, busy_o;
    logic [2:0] pins = 3'h5, addr = 3'h5, dev_addr_low_o;
    logic [8:0] rx;
    wire scl, m_sda;
    wire sda = m_sda & (sda_oe_n_o | sda_o) & peer;
    int miscompares = 0, n_compared = 0, seed = 22225, n_rst = 0;
    int n_busy = 0;
    int exp_q[$];
    smbus_alert_timeout_gencall #(.STUCK_CYCLES(200), .BUSY_CYCLES(20)) DUT (
        .core_clk_i, .rst_i, .scl_i(scl), .sda_i(sda), .sda_o, .sda_oe_n_o,
        .address_select_pins_i(pins), .alarm_mode_select_i(mode),
        .alarm_polarity_i(alarm_polarity), .alarm_event_i(ev), .alarm_upper_i(up),
        .alert_o, .alert_oe_n_o, .regs_reset_o, .busy_o, .dev_addr_low_o);
    smbus_master_model M (.core_clk_i, .sda_line_i(sda), .scl_o(scl),
        .sda_o(m_sda));
    initial forever #10 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) if (regs_reset_o === 1'b1) n_rst++;
    always @(posedge core_clk_i) if (busy_o === 1'b1) n_busy++;
    task automatic chk(input string what, input logic [8:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic trip(input logic u);
        ev <= 1'b1;
        up <= u;
        @(posedge core_clk_i);
        ev <= 1'b0;
        if (mode && !alarm_polarity) exp_q.push_back({4'h9, addr, u});
        repeat (4) @(posedge core_clk_i);
        chk("alert", exp_q.size() == 0, alert_oe_n_o);
    endtask
    task automatic ara(input logic lose);
        M.start();
        M.bits({smbus_ext_pkg::ALERT_RESP_ADDR, 1'b1}, 9, rx);
        chk("ara ack", exp_q.size() == 0, rx[0]);
        if (!rx[0]) begin
            peer <= !lose;
            M.bits(9'h1ff, 9, rx);
            peer <= 1'b1;
            if (!lose) chk("resp", exp_q.pop_front(), rx[8:1]);
        end
        M.stop();
        repeat (6) @(posedge core_clk_i);
        chk("alert", exp_q.size() == 0, alert_oe_n_o);
    endtask
    task automatic gc(input logic [7:0] a, c);
        M.start();
        M.bits({a, 1'b1}, 9, rx);
        chk("gc ack", a != 8'h00, rx[0]);
        if (!rx[0]) M.bits({c, 1'b1}, 9, rx);
        M.stop();
        repeat (6) @(posedge core_clk_i);
        chk("addr", addr, dev_addr_low_o);
    endtask
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        chk("idle", 3'h6, {sda_oe_n_o, alert_oe_n_o, busy_o});
        chk("alert pin", 1'b0, alert_o);
        chk("addr", addr, dev_addr_low_o);
        ara(1'b0);
        for (int i = 0; i < 4; i++) begin
            M.half = 10 + 10 * (i % 2);
            trip($random(seed));
            ara(i == 1);
            if (exp_q.size() > 0) ara(1'b0);
        end
        pins <= $random(seed);
        gc(8'h00, 8'h05);
        gc(8'h01, smbus_ext_pkg::CMD_RELATCH);
        addr = pins;
        gc(8'h00, smbus_ext_pkg::CMD_RELATCH);
        addr = $random(seed);
        pins <= addr;
        gc(8'h00, smbus_ext_pkg::CMD_RESET);
        chk("regs reset", 9'h001, n_rst);
        repeat (30) @(posedge core_clk_i);
        chk("busy", 1'b0, busy_o);
        chk("busy span", 1'b1, n_busy > 0 && n_busy <= 20);
        trip(1'b0);
        M.start();
        M.bits({smbus_ext_pkg::ALERT_RESP_ADDR, 1'b1}, 8, rx);
        repeat (20) @(posedge core_clk_i);
        chk("ack low", 1'b0, sda);
        repeat (200) @(posedge core_clk_i);
        chk("released", 1'b1, sda);
        ara(1'b0);
        mode <= 1'b0;
        trip(1'b1);
        ara(1'b0);
        mode <= 1'b1;
        alarm_polarity <= 1'b1;
        trip(1'b0);
        ara(1'b0);
        final_report();
    end
    initial begin
        repeat (80000) @(posedge core_clk_i);
        miscompares++;
        final_report();
    end
endmodule
`default_nettype wire
